// ==== rtl/capability_cfg.svh ====
// Constants for the sampling capability report: offsets, field positions, resets
// Operation
// - Availability bit 0 copies bit 62 of the extended feature enable register.
// - Bit 0 reads 1 only if hardware supports and software enabled sampling.
// - Availability bits 31:1 come from the sampling configuration register.
// - Every availability bit set is also set in the full capability word.
// - Full capability word shows all hardware features, whatever software enabled.
// - Bits 1 to 6 flag events with matching identifiers; bits 28:7 reserved.
// - Bit 29 set when continuous sampling can be used.
// - Bit 30 set when records may carry the timestamp counter value.
// - Bit 31 set when the buffer threshold interrupt can be used.
// - Geometry bits 7:0 give control block quadwords, at least offset/8 plus maximum.
// - Geometry bits 15:8 give event record bytes, 32 in first version.
// - Geometry bits 23:16 give highest event identifier, never the insert identifier.
// - Geometry bits 31:24 give event area byte offset, a multiple of 8.
`ifndef CAPABILITY_CFG_SVH
`define CAPABILITY_CFG_SVH

`define QUERY_LEAF          32'h8000_001C
`define ENABLE_BIT_POS      62
`define AVAIL_BIT           0
`define CONT_BIT            29
`define PTSC_BIT            30
`define INT_BIT             31
`define RESERVED_MASK       32'h1FFF_FF80
`define CFG_WRITABLE_MASK   32'hE000_007E
`define CFG_RESET           32'h0000_0000
`define ENABLE_RESET        64'h0000_0000_0000_0000
`define FULL_CAP_DEFAULT    32'hE000_007F
`define QWORD_BYTES         8
`define RECORD_BYTES_V1     8'h20
`define USER_INSERT_ID      8'hFF
`define MAX_EVENT_DEFAULT   8'h06
`define EVENT_OFFSET_DEF    8'h80
`define CB_QWORDS_DEFAULT   8'h16

`endif

// ==== rtl/capability_pkg.sv ====
// Types shared by the capability report modules
`default_nettype none
package capability_pkg;
  typedef logic [31:0] word_t;
  typedef struct packed {
    logic [7:0] event_area_offset;
    logic [7:0] highest_event_identifier;
    logic [7:0] event_record_bytes;
    logic [7:0] control_block_quadwords;
  } geometry_s;
endpackage : capability_pkg
`default_nettype wire

// ==== rtl/capability_if.sv ====
// Signals passed between the report top and its word builders
`timescale 1ns/1ps
`default_nettype none
interface capability_if;
  import capability_pkg::*;
  logic      enable_bit;
  word_t     config_bits;
  word_t     full_capability;
  word_t     feature_word;
  geometry_s geometry_word;
  modport top_side (output enable_bit, config_bits, full_capability,
                    input feature_word, geometry_word);
  modport feature_side (input enable_bit, config_bits, full_capability,
                        output feature_word);
  modport geometry_side (output geometry_word);
endinterface : capability_if
`default_nettype wire

// ==== rtl/feature_word_builder.sv ====
// Combines enable bit and configuration bits into the availability word
`timescale 1ns/1ps
`default_nettype none
`include "capability_cfg.svh"
module feature_word_builder
(
  capability_if.feature_side cap
);
  import capability_pkg::*;

  // Configuration bits limited to hardware features, enable bit in bit 0
  always_comb
  begin
    cap.feature_word = cap.config_bits & cap.full_capability & `CFG_WRITABLE_MASK;
    cap.feature_word[`AVAIL_BIT] = cap.enable_bit;
  end
endmodule : feature_word_builder
`default_nettype wire

// ==== rtl/geometry_word_builder.sv ====
// Builds the constant sampling geometry word from sizing parameters
`timescale 1ns/1ps
`default_nettype none
`include "capability_cfg.svh"
module geometry_word_builder
#(
  parameter logic [7:0] CB_QWORDS    = `CB_QWORDS_DEFAULT,
  parameter logic [7:0] RECORD_BYTES = `RECORD_BYTES_V1,
  parameter logic [7:0] MAX_EVENT    = `MAX_EVENT_DEFAULT,
  parameter logic [7:0] EVENT_OFFSET = `EVENT_OFFSET_DEF
)
(
  capability_if.geometry_side cap
);
  import capability_pkg::*;

  // Rounds an offset up to the next quadword boundary
  function automatic logic [7:0] align_qword(input logic [7:0] value);
    logic [8:0] sum;
    sum = {1'b0, value} + 9'h007;
    return sum[8] ? 8'hF8 : {sum[7:3], 3'b000}; // Saturate, never wrap to zero
  endfunction : align_qword

  // Smallest block that still holds every event interval field
  function automatic logic [7:0] least_block(input logic [7:0] offset,
                                             input logic [7:0] max_id);
    logic [8:0] sum;
    sum = {4'h0, offset[7:3]} + {1'b0, max_id};
    return sum[8] ? 8'hFF : sum[7:0];
  endfunction : least_block

  localparam logic [7:0] OFFSET_USED = align_qword(EVENT_OFFSET);
  localparam logic [7:0] MAX_USED    = (MAX_EVENT == `USER_INSERT_ID) ?
                                       8'hFE : MAX_EVENT;
  localparam logic [7:0] CB_LEAST    = least_block(OFFSET_USED, MAX_USED);
  localparam logic [7:0] CB_USED     = (CB_QWORDS < CB_LEAST) ? CB_LEAST : CB_QWORDS;

  // Fields packed in descriptor order
  always_comb
  begin
    cap.geometry_word.control_block_quadwords  = CB_USED;
    cap.geometry_word.event_record_bytes       = RECORD_BYTES;
    cap.geometry_word.highest_event_identifier = MAX_USED;
    cap.geometry_word.event_area_offset        = OFFSET_USED;
  end
endmodule : geometry_word_builder
`default_nettype wire

// ==== rtl/profiling_capability_report.sv ====
// Capability report for the lightweight event sampling identification leaf
`timescale 1ns/1ps
`default_nettype none
`include "capability_cfg.svh"
module profiling_capability_report
#(
  parameter capability_pkg::word_t FULL_CAPABILITY = `FULL_CAP_DEFAULT,
  parameter logic [7:0]            CB_QWORDS       = `CB_QWORDS_DEFAULT,
  parameter logic [7:0]            RECORD_BYTES    = `RECORD_BYTES_V1,
  parameter logic [7:0]            MAX_EVENT       = `MAX_EVENT_DEFAULT,
  parameter logic [7:0]            EVENT_OFFSET    = `EVENT_OFFSET_DEF
)
(
  input  wire  logic                  clock,
  input  wire  logic                  rst,
  input  wire  logic                  query_valid,
  input  wire  capability_pkg::word_t query_leaf,
  input  wire  logic                  cfg_write,
  input  wire  capability_pkg::word_t cfg_data,
  input  wire  logic                  enable_write,
  input  wire  logic [63:0]           enable_data,
  output var   logic                  answer_valid,
  output var   logic                  answer_hit,
  output var   capability_pkg::word_t answer_feature,
  output var   capability_pkg::word_t answer_geometry,
  output var   capability_pkg::word_t answer_full,
  output var   capability_pkg::word_t cfg_readback,
  output var   logic [63:0]           enable_readback
);
  import capability_pkg::*;

  capability_if cap ();

  logic [63:0] enable_reg;
  word_t       config_reg;
  logic        leaf_hit;
  logic        hw_supported;

  assign hw_supported = FULL_CAPABILITY[`AVAIL_BIT];
  assign leaf_hit     = (query_leaf == `QUERY_LEAF);

  // Extended feature enable register; sampling bit sticks at 0 without hardware
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      enable_reg <= `ENABLE_RESET;
    else if (enable_write)
    begin
      enable_reg                  <= enable_data;
      enable_reg[`ENABLE_BIT_POS] <= enable_data[`ENABLE_BIT_POS] & hw_supported;
    end
  end

  // Sampling configuration register; only offered hardware features are kept
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      config_reg <= `CFG_RESET;
    else if (cfg_write)
      config_reg <= cfg_data & FULL_CAPABILITY & `CFG_WRITABLE_MASK;
  end

  // Interface feeds for the word builders
  always_comb
  begin
    cap.enable_bit      = enable_reg[`ENABLE_BIT_POS];
    cap.config_bits     = config_reg;
    cap.full_capability = FULL_CAPABILITY;
  end

  feature_word_builder u_feature
  (
    .cap (cap.feature_side)
  );

  geometry_word_builder
  #(
    .CB_QWORDS    (CB_QWORDS),
    .RECORD_BYTES (RECORD_BYTES),
    .MAX_EVENT    (MAX_EVENT),
    .EVENT_OFFSET (EVENT_OFFSET)
  )
  u_geometry
  (
    .cap (cap.geometry_side)
  );

  // Answer strobe, one cycle after each query
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      answer_valid <= 1'b0;
      answer_hit   <= 1'b0;
    end
    else
    begin
      answer_valid <= query_valid;
      answer_hit   <= query_valid & leaf_hit;
    end
  end

  // Answer words; other leaves answer zero, reads change no state
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      answer_feature  <= 32'h0000_0000;
      answer_geometry <= 32'h0000_0000;
      answer_full     <= 32'h0000_0000;
    end
    else if (query_valid)
    begin
      answer_feature  <= leaf_hit ? cap.feature_word : 32'h0000_0000;
      answer_geometry <= leaf_hit ? cap.geometry_word : 32'h0000_0000;
      answer_full     <= leaf_hit ? FULL_CAPABILITY : 32'h0000_0000;
    end
  end

  // Register readback for the privileged side
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cfg_readback    <= `CFG_RESET;
      enable_readback <= `ENABLE_RESET;
    end
    else
    begin
      cfg_readback    <= config_reg;
      enable_readback <= enable_reg;
    end
  end

  // Bit 0 of a hit answer follows the enable bit at query time
  avail_copy_a: assert property (@(posedge clock) disable iff (rst)
    (query_valid && leaf_hit) |=>
      answer_feature[`AVAIL_BIT] == $past(enable_reg[`ENABLE_BIT_POS]))
    else $error("availability bit differs from enable bit");

  // Enable bit never set without hardware support
  avail_gate_a: assert property (@(posedge clock) disable iff (rst)
    answer_valid && answer_hit && answer_feature[`AVAIL_BIT] |-> hw_supported)
    else $error("availability reported without hardware support");

  // Upper availability bits follow the configuration register
  cfg_source_a: assert property (@(posedge clock) disable iff (rst)
    (query_valid && leaf_hit) |=> answer_feature[31:1] == $past(config_reg[31:1]))
    else $error("availability bits differ from configuration");

  // Availability bits 31:1 never exceed the full capability
  subset_word_a: assert property (@(posedge clock) disable iff (rst)
    answer_valid && answer_hit |-> (answer_feature[31:1] & ~answer_full[31:1]) == 31'h0)
    else $error("availability bit outside full capability");

  // Full capability ignores what software enabled
  full_fixed_a: assert property (@(posedge clock) disable iff (rst)
    answer_valid && answer_hit |-> answer_full == FULL_CAPABILITY)
    else $error("full capability word altered");

  // Reserved availability bits read zero
  reserved_zero_a: assert property (@(posedge clock) disable iff (rst)
    answer_valid |-> (answer_feature & `RESERVED_MASK) == 32'h0000_0000)
    else $error("reserved availability bit set");

  // Top feature bits track a configuration write
  top_bits_a: assert property (@(posedge clock) disable iff (rst)
    (cfg_write && !query_valid) ##1 (query_valid && leaf_hit) |=>
      answer_feature[31:29] == ($past(cfg_data[31:29], 2) & FULL_CAPABILITY[31:29]))
    else $error("mode bits lost after configuration write");

  // Control block large enough for all interval fields
  cb_size_a: assert property (@(posedge clock) disable iff (rst)
    answer_valid && answer_hit |->
      {1'b0, answer_geometry[7:0]} >=
      ({4'h0, answer_geometry[31:27]} + {1'b0, answer_geometry[23:16]}))
    else $error("control block size too small");

  // Record size as configured
  record_size_a: assert property (@(posedge clock) disable iff (rst)
    answer_valid && answer_hit |-> answer_geometry[15:8] == RECORD_BYTES)
    else $error("event record size wrong");

  // Highest identifier never the insert identifier
  max_event_a: assert property (@(posedge clock) disable iff (rst)
    answer_valid && answer_hit |-> answer_geometry[23:16] != `USER_INSERT_ID)
    else $error("highest event identifier is the insert identifier");

  // Event area offset quadword aligned
  offset_align_a: assert property (@(posedge clock) disable iff (rst)
    answer_valid && answer_hit |-> answer_geometry[26:24] == 3'b000)
    else $error("event area offset not aligned");

  // Exactly one answer per query, none otherwise
  answer_once_a: assert property (@(posedge clock) disable iff (rst)
    query_valid ##1 !query_valid |-> answer_valid ##1 !answer_valid)
    else $error("answer strobe count wrong");

  // Back to back reads without writes repeat the same words
  repeat_read_a: assert property (@(posedge clock) disable iff (rst)
    (query_valid && leaf_hit && !cfg_write && !enable_write) ##1
    (query_valid && leaf_hit) |=>
      (answer_feature == $past(answer_feature)) && (answer_geometry == $past(answer_geometry)))
    else $error("repeated read returned a different value");
endmodule : profiling_capability_report
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the sampling capability report
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import capability_pkg::*;
  localparam word_t LEAF = 32'h8000_001C;
  localparam word_t FULL = 32'hE000_007F;
  localparam word_t LEAN = 32'h2000_000A;
  localparam word_t GEOM = 32'h8006_2016;
  localparam word_t OFFERABLE = 32'hE000_007E;
  logic        clock;
  logic        rst;
  logic        query_valid;
  word_t       query_leaf;
  logic        cfg_write;
  word_t       cfg_data;
  logic        enable_write;
  logic [63:0] enable_data;
  logic        answer_valid;
  logic        answer_hit;
  word_t       answer_feature;
  word_t       answer_geometry;
  word_t       answer_full;
  word_t       cfg_readback;
  logic [63:0] enable_readback;
  logic        lean_valid;
  word_t       lean_feature;
  word_t       lean_full;
  word_t       lean_geometry;
  word_t       cfg_raw;
  logic        en_raw;
  int          errors;
  int          checked;

  // Full-featured device under test
  profiling_capability_report dut (.clock(clock), .rst(rst), .query_valid(query_valid),
    .query_leaf(query_leaf), .cfg_write(cfg_write), .cfg_data(cfg_data),
    .enable_write(enable_write), .enable_data(enable_data), .answer_valid(answer_valid),
    .answer_hit(answer_hit), .answer_feature(answer_feature),
    .answer_geometry(answer_geometry), .answer_full(answer_full),
    .cfg_readback(cfg_readback), .enable_readback(enable_readback));

  // Reduced device without sampling support, shares all inputs
  profiling_capability_report #(.FULL_CAPABILITY(LEAN)) dut_lean (.clock(clock), .rst(rst),
    .query_valid(query_valid), .query_leaf(query_leaf), .cfg_write(cfg_write),
    .cfg_data(cfg_data), .enable_write(enable_write), .enable_data(enable_data),
    .answer_valid(lean_valid), .answer_hit(), .answer_feature(lean_feature),
    .answer_geometry(lean_geometry), .answer_full(lean_full),
    .cfg_readback(), .enable_readback());

  // Clock generator, 40 ns period
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // Single query; answer is due one edge later
  task automatic query(input word_t leaf);
    query_valid = 1'b1;
    query_leaf  = leaf;
    @(negedge clock);
    query_valid = 1'b0;
  endtask : query

  task automatic write_cfg(input word_t d);
    cfg_write = 1'b1;
    cfg_data  = d;
    cfg_raw   = d;
    @(negedge clock);
    cfg_write = 1'b0;
  endtask : write_cfg

  task automatic write_enable(input logic [63:0] d);
    enable_write = 1'b1;
    enable_data  = d;
    en_raw       = d[62];
    @(negedge clock);
    enable_write = 1'b0;
  endtask : write_enable

  // Compare a hit answer against values worked out from the writes
  task automatic expect_hit();
    check("answer_valid", answer_valid, 1'b1);
    check("answer_hit", answer_hit, 1'b1);
    check("feature", answer_feature, (cfg_raw & OFFERABLE) | word_t'(en_raw));
    check("feature_subset", answer_feature & ~answer_full, 0);
    check("full", answer_full, FULL);
    check("geometry", answer_geometry, GEOM);
    check("cb_floor", answer_geometry[7:0] >=
          answer_geometry[31:27] + answer_geometry[23:16], 1);
    check("offset_align", answer_geometry[26:24], 0);
    check("lean_feature", lean_feature, cfg_raw & LEAN & OFFERABLE);
    check("lean_full", lean_full, LEAN);
    // Pool view: features common to both devices, least common geometry
    check("pool_feature", answer_feature & lean_feature, cfg_raw & LEAN & OFFERABLE);
    check("pool_full", answer_full & lean_full, LEAN);
    check("pool_geometry", lean_geometry, GEOM);
  endtask : expect_hit

  // Main sequence
  initial
  begin
    errors = 0;
    checked = 0;
    rst = 1'b1;
    query_valid = 1'b0;
    query_leaf = '0;
    cfg_write = 1'b0;
    cfg_data = '0;
    enable_write = 1'b0;
    enable_data = '0;
    cfg_raw = '0;
    en_raw = 1'b0;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    check("cfg_reset", cfg_readback, 0);
    check("enable_reset", enable_readback, 0);
    query(LEAF);
    expect_hit();
    write_enable(64'h4000_0000_0000_0000);
    query(LEAF);
    expect_hit();
    check("enable_readback", enable_readback[62], 1'b1);
    check("lean_avail", lean_feature[0], 1'b0);
    // Walk configuration bits 1 to 31, each on its own
    for (int i = 1; i < 32; i++)
    begin
      write_cfg(word_t'(1) << i);
      query(LEAF);
      expect_hit();
    end
    write_cfg(32'hFFFF_FFFF);
    // Readback lags the stored value by one edge
    @(negedge clock);
    check("cfg_readback", cfg_readback, OFFERABLE);
    // Write and query in one cycle: query sees the old value
    cfg_write = 1'b1;
    cfg_data = 32'h2000_0002;
    query(LEAF);
    cfg_write = 1'b0;
    expect_hit();
    cfg_raw = 32'h2000_0002;
    // Back-to-back queries, then held words
    @(negedge clock);
    query_valid = 1'b1;
    query_leaf = LEAF;
    @(negedge clock);
    expect_hit();
    @(negedge clock);
    query_valid = 1'b0;
    expect_hit();
    @(negedge clock);
    check("valid_drop", answer_valid, 1'b0);
    check("feature_held", answer_feature, 32'h2000_0003);
    write_enable(64'hBFFF_FFFF_FFFF_FFFF);
    query(LEAF);
    expect_hit();
    // Other leaf answers with the strobe, hit low and all words zero
    @(negedge clock);
    query(32'h8000_001B);
    check("miss_valid", answer_valid, 1'b1);
    check("miss_hit", answer_hit, 1'b0);
    check("miss_words", {answer_feature, answer_geometry | answer_full}, 0);
    check("lean_valid", lean_valid, 1'b1);
    final_report();
  end
endmodule : testbench
`default_nettype wire
